// ===== src/dser_responder.sv
`timescale 1ns/1ps
`include "dser_consts.svh"
// Summary of operation
// - link word: bit0 write storing, bit3 range error, bit4 verify fault.
// - secondary fault word: six fault flags bits 0-5, rest zero.
// - warning word: halt bits 0 and 14, warnings bits 1-8, 12, 13.
// - input word mirrors seven input pins in bits 0-6.
// - primary status: run, zero speed, frequency agree, nonfatal alarm in bits 0-3.
// - primary status: frequency detect 4-5, ready 6, undervoltage 7, blocked 8.
// - primary status: bit9 reference not from link, bit10 run not from link.
// - primary status: overtorque 11, fault retry 13, fault 14, bit 12 zero.
// - primary status bit 15 set after two seconds without valid traffic.
// - output word: relay bit0, photo outputs bits 1 and 2.
// - secondary status: reference loss in bit 0 only.
// - error word: checksum 0, length 1, parity 3, overrun 4, framing 5, timeout 6.
// - exception reply: address, function with msb set, code, crc-16.
// - code 01 for function codes other than 03, 08, 10.
// - code 02 for undefined register or read of commit register.
// - code 03 for count outside 1-16 or byte count mismatch.
// - code 21 for out-of-range write data or setting error.
// - code 22 for locked parameter write or commit while running.
// - code 22 for writes or commit during main undervoltage.
// - code 22 for writes during init memory fault except parameter initialisation 8 or 9.
// - code 22 for write during write processing; master waits before sending.
// - code 22 for a write to a read-only register.
module dser_responder #(
    parameter int TIMEOUT_CYCLES = `DSER_TIMEOUT_CYCLES,
    parameter logic [15:0] COMMIT_REG = `DSER_REG_COMMIT_DEF,
    parameter logic [15:0] INIT_PARAM_REG = `DSER_REG_INIT_PARAM_DEF
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_slave_addr,
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire logic [7:0] i_req_func,
    input wire logic [15:0] i_req_reg,
    input wire logic [15:0] i_req_count,
    input wire logic [7:0] i_req_bytes,
    input wire logic [15:0] i_req_first_data,
    input wire logic i_data_out_of_range,
    input wire logic i_operation_setting_error,
    input wire logic i_ext_defined,
    input wire logic i_ext_read_only,
    input wire logic i_ext_locked_in_run,
    input wire logic i_init_memory_fault,
    output logic o_rsp_valid,
    output logic o_rsp_exception,
    output logic [7:0] o_rsp_addr,
    output logic [7:0] o_rsp_func,
    output logic [7:0] o_rsp_code,
    output logic [15:0] o_rsp_crc,
    output logic o_write_go,
    input wire logic i_write_storing,
    input wire logic i_frame_ok,
    input wire logic i_rd_en,
    input wire logic [15:0] i_rd_reg,
    output logic o_rd_valid,
    output logic o_rd_hit,
    output logic [15:0] o_rd_data,
    input wire logic i_output_short_fault,
    input wire logic i_ground_leak_fault,
    input wire logic i_input_phase_fault,
    input wire logic i_output_phase_fault,
    input wire logic i_brake_resistor_fault,
    input wire logic i_brake_switch_fault,
    input wire logic i_emergency_halt,
    input wire logic i_sequence_warning,
    input wire logic i_external_warning,
    input wire logic i_output_blocked,
    input wire logic i_overtorque_warning,
    input wire logic i_overheat_warning,
    input wire logic i_overvoltage_warning,
    input wire logic i_main_undervoltage,
    input wire logic i_cooling_fan_warning,
    input wire logic i_heatsink_warning,
    input wire logic i_feedback_loss,
    input wire logic [6:0] i_input_pins,
    input wire logic i_running,
    input wire logic i_zero_speed,
    input wire logic i_freq_agree,
    input wire logic i_nonfatal_alarm,
    input wire logic i_freq_detect_one,
    input wire logic i_freq_detect_two,
    input wire logic i_ready,
    input wire logic i_ref_not_link,
    input wire logic i_run_not_link,
    input wire logic i_overtorque_detect,
    input wire logic i_fault_retry,
    input wire logic i_fault,
    input wire logic i_relay_contact_out,
    input wire logic i_photo_out_one,
    input wire logic i_photo_out_two,
    input wire logic i_ref_loss,
    input wire logic i_err_checksum,
    input wire logic i_err_length,
    input wire logic i_err_parity,
    input wire logic i_err_overrun,
    input wire logic i_err_framing
);
    localparam int TMR_W = $clog2(TIMEOUT_CYCLES + 1);

    generate
        if (TIMEOUT_CYCLES < 1) begin : g_bad_timeout
            $error("TIMEOUT_CYCLES must be at least one");
        end
    endgenerate

    logic rst_meta_q;
    logic rst_sync_q;
    logic nrst;
    dser_pkg::dser_state_t state_q;
    logic [7:0] func_q;
    logic [15:0] reg_q;
    logic [15:0] count_q;
    logic [7:0] bytes_q;
    logic [15:0] first_q;
    logic range_q;
    logic clash_q;
    logic ext_def_q;
    logic ext_ro_q;
    logic ext_lock_q;
    logic [7:0] code_q;
    logic [TMR_W-1:0] silence_q;
    logic timeout_q;
    logic [15:0] lws_q;
    logic [15:0] sec_fault_q;
    logic [15:0] warn_q;
    logic [15:0] in_pins_q;
    logic [15:0] drv_pri_q;
    logic [15:0] out_pins_q;
    logic [15:0] drv_sec_q;
    logic [15:0] link_err_q;

    dser_chk_if chk_bus ();

    // reset release through two flops
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign nrst = rst_sync_q;

    function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ `DSER_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc16_step

    assign o_req_ready = (state_q == dser_pkg::DSER_ST_IDLE);

    // request capture
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            func_q <= 8'h00;
            reg_q <= 16'h0000;
            count_q <= 16'h0000;
            bytes_q <= 8'h00;
            first_q <= 16'h0000;
            range_q <= 1'b0;
            clash_q <= 1'b0;
            ext_def_q <= 1'b0;
            ext_ro_q <= 1'b0;
            ext_lock_q <= 1'b0;
        end else if (i_req_valid && o_req_ready) begin
            func_q <= i_req_func;
            reg_q <= i_req_reg;
            count_q <= i_req_count;
            bytes_q <= i_req_bytes;
            first_q <= i_req_first_data;
            range_q <= i_data_out_of_range;
            clash_q <= i_operation_setting_error;
            ext_def_q <= i_ext_defined;
            ext_ro_q <= i_ext_read_only;
            ext_lock_q <= i_ext_locked_in_run;
        end
    end

    assign chk_bus.func = func_q;
    assign chk_bus.reg_addr = reg_q;
    assign chk_bus.reg_count = count_q;
    assign chk_bus.byte_count = bytes_q;
    assign chk_bus.first_data = first_q;
    assign chk_bus.data_out_of_range = range_q;
    assign chk_bus.data_clash = clash_q;
    assign chk_bus.running = i_running;
    assign chk_bus.main_undervoltage = i_main_undervoltage;
    assign chk_bus.init_memory_fault = i_init_memory_fault;
    assign chk_bus.write_in_progress = i_write_storing;
    assign chk_bus.ext_defined = ext_def_q;
    assign chk_bus.ext_read_only = ext_ro_q;
    assign chk_bus.ext_locked_in_run = ext_lock_q;

    dser_req_check #(
        .COMMIT_REG(COMMIT_REG),
        .INIT_PARAM_REG(INIT_PARAM_REG)
    ) u_check (
        .chk(chk_bus)
    );

    // idle -> check -> reply
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= dser_pkg::DSER_ST_IDLE;
        end else begin
            case (state_q)
                dser_pkg::DSER_ST_IDLE: begin
                    if (i_req_valid) begin
                        state_q <= dser_pkg::DSER_ST_CHECK;
                    end
                end
                dser_pkg::DSER_ST_CHECK: begin
                    state_q <= dser_pkg::DSER_ST_REPLY;
                end
                default: begin
                    state_q <= dser_pkg::DSER_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            code_q <= `DSER_EC_NONE;
        end else if (state_q == dser_pkg::DSER_ST_CHECK) begin
            code_q <= chk_bus.code;
        end
    end

    // reply fields; exception carries flagged function and crc
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            o_rsp_valid <= 1'b0;
            o_rsp_exception <= 1'b0;
            o_rsp_addr <= 8'h00;
            o_rsp_func <= 8'h00;
            o_rsp_code <= 8'h00;
            o_rsp_crc <= 16'h0000;
            o_write_go <= 1'b0;
        end else if (state_q == dser_pkg::DSER_ST_CHECK) begin
            o_rsp_valid <= 1'b1;
            o_rsp_exception <= (chk_bus.code != `DSER_EC_NONE);
            o_rsp_addr <= i_slave_addr;
            o_write_go <= (chk_bus.code == `DSER_EC_NONE) && (func_q == `DSER_FN_WRITE);
            if (chk_bus.code != `DSER_EC_NONE) begin
                o_rsp_func <= func_q | `DSER_FN_EXC_FLAG;
                o_rsp_code <= chk_bus.code;
                o_rsp_crc <= crc16_step(crc16_step(crc16_step(`DSER_CRC_INIT, i_slave_addr),
                    func_q | `DSER_FN_EXC_FLAG), chk_bus.code);
            end else begin
                o_rsp_func <= func_q;
                o_rsp_code <= `DSER_EC_NONE;
                o_rsp_crc <= 16'h0000;
            end
        end else begin
            o_rsp_valid <= 1'b0;
            o_write_go <= 1'b0;
        end
    end

    // silence timer, restarted by each good frame
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            silence_q <= '0;
            timeout_q <= 1'b0;
        end else if (i_frame_ok) begin
            silence_q <= '0;
            timeout_q <= 1'b0;
        end else if (silence_q >= TMR_W'(TIMEOUT_CYCLES - 1)) begin
            timeout_q <= 1'b1;
        end else begin
            silence_q <= silence_q + TMR_W'(1);
        end
    end

    // status snapshots; unused bits tied zero, no write path
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            lws_q <= 16'h0000;
            sec_fault_q <= 16'h0000;
            warn_q <= 16'h0000;
            in_pins_q <= 16'h0000;
            out_pins_q <= 16'h0000;
            drv_sec_q <= 16'h0000;
            link_err_q <= 16'h0000;
        end else begin
            lws_q <= 16'h0000;
            lws_q[`DSER_LWS_WRITING] <= i_write_storing;
            lws_q[`DSER_LWS_RANGE] <= i_data_out_of_range;
            lws_q[`DSER_LWS_VERIFY] <= i_operation_setting_error;
            sec_fault_q <= {10'h000, i_brake_switch_fault, i_brake_resistor_fault, i_output_phase_fault,
                i_input_phase_fault, i_ground_leak_fault, i_output_short_fault};
            warn_q <= {1'b0, i_emergency_halt, i_feedback_loss, i_heatsink_warning, 3'h0, i_cooling_fan_warning,
                i_main_undervoltage, i_overvoltage_warning, i_overheat_warning, i_overtorque_warning,
                i_output_blocked, i_external_warning, i_sequence_warning, i_emergency_halt};
            in_pins_q <= {9'h000, i_input_pins};
            out_pins_q <= {13'h0000, i_photo_out_two, i_photo_out_one, i_relay_contact_out};
            drv_sec_q <= {15'h0000, i_ref_loss};
            link_err_q <= {9'h000, timeout_q, i_err_framing, i_err_overrun, i_err_parity, 1'b0, i_err_length,
                i_err_checksum};
        end
    end

    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            drv_pri_q <= 16'h0000;
        end else begin
            drv_pri_q[3:0] <= {i_nonfatal_alarm, i_freq_agree, i_zero_speed, i_running};
            drv_pri_q[8:4] <= {i_output_blocked, i_main_undervoltage, i_ready, i_freq_detect_two,
                i_freq_detect_one};
            drv_pri_q[10:9] <= {i_run_not_link, i_ref_not_link};
            drv_pri_q[14:11] <= {i_fault, i_fault_retry, 1'b0, i_overtorque_detect};
            drv_pri_q[`DSER_DSP_COMM_TIMEOUT] <= timeout_q;
        end
    end

    // read port, unmapped numbers read zero without hit
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            o_rd_valid <= 1'b0;
            o_rd_hit <= 1'b0;
            o_rd_data <= 16'h0000;
        end else begin
            o_rd_valid <= i_rd_en;
            o_rd_hit <= 1'b0;
            o_rd_data <= 16'h0000;
            if (i_rd_en) begin
                o_rd_hit <= 1'b1;
                if (i_rd_reg == `DSER_REG_LINK_WRITE_STATE) begin
                    o_rd_data <= lws_q;
                end else if (i_rd_reg == `DSER_REG_SECONDARY_FAULT) begin
                    o_rd_data <= sec_fault_q;
                end else if (i_rd_reg == `DSER_REG_WARNING) begin
                    o_rd_data <= warn_q;
                end else if (i_rd_reg == `DSER_REG_INPUT_PINS) begin
                    o_rd_data <= in_pins_q;
                end else if (i_rd_reg == `DSER_REG_DRIVE_PRIMARY) begin
                    o_rd_data <= drv_pri_q;
                end else if (i_rd_reg == `DSER_REG_OUTPUT_PINS) begin
                    o_rd_data <= out_pins_q;
                end else if (i_rd_reg == `DSER_REG_DRIVE_SECONDARY) begin
                    o_rd_data <= drv_sec_q;
                end else if (i_rd_reg == `DSER_REG_LINK_ERRORS) begin
                    o_rd_data <= link_err_q;
                end else begin
                    o_rd_hit <= 1'b0;
                end
            end
        end
    end
endmodule : dser_responder

// ===== src/dser_consts.svh
`ifndef DSER_CONSTS_SVH
`define DSER_CONSTS_SVH

// register numbers of the status words
`define DSER_REG_LINK_WRITE_STATE 16'h0022
`define DSER_REG_SECONDARY_FAULT 16'h0029
`define DSER_REG_WARNING 16'h002a
`define DSER_REG_INPUT_PINS 16'h002b
`define DSER_REG_DRIVE_PRIMARY 16'h002c
`define DSER_REG_OUTPUT_PINS 16'h002d
`define DSER_REG_DRIVE_SECONDARY 16'h002e
`define DSER_REG_LINK_ERRORS 16'h003d

// link write state fields
`define DSER_LWS_WRITING 0
`define DSER_LWS_RANGE 3
`define DSER_LWS_VERIFY 4

// drive primary status fields
`define DSER_DSP_COMM_TIMEOUT 15

// function codes
`define DSER_FN_READ 8'h03
`define DSER_FN_LOOPBACK 8'h08
`define DSER_FN_WRITE 8'h10
`define DSER_FN_EXC_FLAG 8'h80

// exception codes
`define DSER_EC_NONE 8'h00
`define DSER_EC_FUNCTION 8'h01
`define DSER_EC_REGISTER 8'h02
`define DSER_EC_COUNT 8'h03
`define DSER_EC_DATA 8'h21
`define DSER_EC_WRITE_MODE 8'h22

// register count window
`define DSER_COUNT_MIN 16'h0001
`define DSER_COUNT_MAX 16'h0010

// commit and init registers, init values
`define DSER_REG_COMMIT_DEF 16'h0900
`define DSER_REG_INIT_PARAM_DEF 16'h0101
`define DSER_INIT_VAL_A 16'h0008
`define DSER_INIT_VAL_B 16'h0009

// crc-16 of the exception reply
`define DSER_CRC_INIT 16'hffff
`define DSER_CRC_POLY 16'ha001

// link silence limit
`define DSER_CLK_HZ 100000000
`define DSER_TIMEOUT_S 2
`define DSER_TIMEOUT_CYCLES (`DSER_CLK_HZ * `DSER_TIMEOUT_S)

`endif

// ===== src/dser_pkg.sv
package dser_pkg;

    typedef enum logic [1:0] {
        DSER_ST_IDLE = 2'b00,
        DSER_ST_CHECK = 2'b01,
        DSER_ST_REPLY = 2'b11
    } dser_state_t;

    typedef logic [7:0] dser_code_t;

endpackage : dser_pkg

// ===== src/dser_chk_if.sv
`timescale 1ns/1ps
interface dser_chk_if;
    logic [7:0] func;
    logic [15:0] reg_addr;
    logic [15:0] reg_count;
    logic [7:0] byte_count;
    logic [15:0] first_data;
    logic data_out_of_range;
    logic data_clash;
    logic running;
    logic main_undervoltage;
    logic init_memory_fault;
    logic write_in_progress;
    logic ext_defined;
    logic ext_read_only;
    logic ext_locked_in_run;
    dser_pkg::dser_code_t code;

    modport host (output func, reg_addr, reg_count, byte_count, first_data, data_out_of_range, data_clash,
        running, main_undervoltage, init_memory_fault, write_in_progress, ext_defined, ext_read_only,
        ext_locked_in_run, input code);
    modport chk (input func, reg_addr, reg_count, byte_count, first_data, data_out_of_range, data_clash,
        running, main_undervoltage, init_memory_fault, write_in_progress, ext_defined, ext_read_only,
        ext_locked_in_run, output code);
endinterface : dser_chk_if

// ===== src/dser_req_check.sv
`timescale 1ns/1ps
`include "dser_consts.svh"
module dser_req_check #(
    parameter logic [15:0] COMMIT_REG = `DSER_REG_COMMIT_DEF,
    parameter logic [15:0] INIT_PARAM_REG = `DSER_REG_INIT_PARAM_DEF
) (
    dser_chk_if.chk chk
);
    logic is_read;
    logic is_write;
    logic own_reg;
    logic is_commit;
    logic is_init;
    logic count_bad;

    always_comb begin
        own_reg = (chk.reg_addr == `DSER_REG_LINK_WRITE_STATE) || (chk.reg_addr == `DSER_REG_SECONDARY_FAULT) ||
            (chk.reg_addr == `DSER_REG_WARNING) || (chk.reg_addr == `DSER_REG_INPUT_PINS) ||
            (chk.reg_addr == `DSER_REG_DRIVE_PRIMARY) || (chk.reg_addr == `DSER_REG_OUTPUT_PINS) ||
            (chk.reg_addr == `DSER_REG_DRIVE_SECONDARY) || (chk.reg_addr == `DSER_REG_LINK_ERRORS);
    end

    assign is_read = (chk.func == `DSER_FN_READ);
    assign is_write = (chk.func == `DSER_FN_WRITE);
    assign is_commit = (chk.reg_addr == COMMIT_REG);
    assign is_init = (chk.reg_addr == INIT_PARAM_REG) &&
        ((chk.first_data == `DSER_INIT_VAL_A) || (chk.first_data == `DSER_INIT_VAL_B));
    assign count_bad = (chk.reg_count < `DSER_COUNT_MIN) || (chk.reg_count > `DSER_COUNT_MAX) ||
        (is_write && ({chk.reg_count[14:0], 1'b0} != {8'h00, chk.byte_count}));

    // first matching cause wins, in order 01, 02, 03, 22, then 21
    always_comb begin
        chk.code = `DSER_EC_NONE;
        if (!is_read && !is_write && (chk.func != `DSER_FN_LOOPBACK)) begin
            chk.code = `DSER_EC_FUNCTION;
        end else if (chk.func == `DSER_FN_LOOPBACK) begin
            chk.code = `DSER_EC_NONE;
        end else if (!(own_reg || is_commit || chk.ext_defined) || (is_read && is_commit)) begin
            chk.code = `DSER_EC_REGISTER;
        end else if (count_bad) begin
            chk.code = `DSER_EC_COUNT;
        end else if (is_write && chk.write_in_progress) begin
            chk.code = `DSER_EC_WRITE_MODE;
        end else if (is_write && (own_reg || chk.ext_read_only)) begin
            chk.code = `DSER_EC_WRITE_MODE;
        end else if (is_write && chk.main_undervoltage) begin
            chk.code = `DSER_EC_WRITE_MODE;
        end else if (is_write && chk.init_memory_fault && !is_init) begin
            chk.code = `DSER_EC_WRITE_MODE;
        end else if (is_write && chk.running && (is_commit || chk.ext_locked_in_run)) begin
            chk.code = `DSER_EC_WRITE_MODE;
        end else if (is_write && (chk.data_out_of_range || chk.data_clash)) begin
            chk.code = `DSER_EC_DATA;
        end
    end
endmodule : dser_req_check

// ===== sim/dser_responder_chk.sv
`timescale 1ns/1ps
module dser_resp_chk (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_req_valid,
    input wire logic o_req_ready,
    input wire logic [7:0] i_req_func,
    input wire logic i_rd_en,
    input wire logic [15:0] i_rd_reg,
    input wire logic o_rsp_valid,
    input wire logic o_rsp_exception,
    input wire logic [7:0] o_rsp_func,
    input wire logic [7:0] o_rsp_code,
    input wire logic o_write_go,
    input wire logic o_rd_valid,
    input wire logic o_rd_hit,
    input wire logic [15:0] o_rd_data
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    wire taken = i_req_valid && o_req_ready;
    a_reply_two_later: assert property (taken |-> ##2 o_rsp_valid)
        else $error("late reply");
    a_busy_two_cycles: assert property (taken |=> !o_req_ready ##1 !o_req_ready ##1 o_req_ready)
        else $error("busy window");
    a_exc_func_msb: assert property (o_rsp_valid && o_rsp_exception |-> o_rsp_func[7] && o_rsp_code != 8'h00)
        else $error("bad exception");
    a_bad_func_code: assert property (taken && !(i_req_func inside {8'h03, 8'h08, 8'h10})
        |-> ##2 o_rsp_exception && o_rsp_code == 8'h01) else $error("no code 01");
    a_loopback_clean: assert property (taken && i_req_func == 8'h08 |-> ##2 !o_rsp_exception)
        else $error("loopback refused");
    a_go_on_write: assert property (o_write_go |-> o_rsp_valid && !o_rsp_exception && o_rsp_func == 8'h10)
        else $error("stray write start");
    a_read_answer: assert property (i_rd_en |=> o_rd_valid)
        else $error("read not answered");
    a_miss_reads_zero: assert property (o_rd_valid && !o_rd_hit |-> o_rd_data == 16'h0000)
        else $error("miss not zero");
    a_sec_unused_zero: assert property (o_rd_valid && $past(i_rd_reg) == 16'h002e |-> o_rd_data[15:1] == 15'h0000)
        else $error("unused bits set");
    c_write_go: cover property (o_write_go);
    c_exception: cover property (o_rsp_valid && o_rsp_exception);
    c_read_hit: cover property (o_rd_valid && o_rd_hit);
endmodule : dser_resp_chk
bind dser_responder dser_resp_chk chk_u (.*);

// ===== sim/dser_master_model.sv
`timescale 1ns/1ps
module dser_master_model (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [63:0] i_fields,
    input wire logic i_ready,
    output logic o_valid,
    output logic [63:0] o_fields
);
    initial {o_valid, o_fields} = '0;
    // hold until taken, scramble on release
    always @(posedge i_clk) begin
        if (i_go) begin
            o_valid <= 1'b1;
            o_fields <= i_fields;
        end else if (o_valid && i_ready) begin
            o_valid <= 1'b0;
            o_fields <= ~o_fields;
        end
    end
endmodule : dser_master_model

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, nrst = 1'b0, go = 1'b0, fok = 1'b0, rd_en = 1'b0, rv, rdy, rsp_v, rsp_e, wgo, rd_v, rd_h;
    logic [7:0] sa = 8'h5a, rsp_a, rsp_f, rsp_c;
    logic [15:0] rd_reg = '0, rsp_crc, rd_d;
    logic [51:0] s = '0;
    logic [63:0] mfl = '0, rq;
    int failures = 0, check_count = 0;
    initial forever #5 clk = ~clk;
    dser_master_model master_u (.i_clk(clk), .i_go(go), .i_fields(mfl), .i_ready(rdy), .o_valid(rv), .o_fields(rq));
    dser_responder #(.TIMEOUT_CYCLES(20)) dut_u (.i_clk(clk), .i_nrst(nrst), .i_slave_addr(sa), .i_req_valid(rv),
        .o_req_ready(rdy), .i_req_func(rq[63:56]), .i_req_reg(rq[55:40]), .i_req_count(rq[39:24]),
        .i_req_bytes(rq[23:16]), .i_req_first_data(rq[15:0]), .i_data_out_of_range(s[0]),
        .i_operation_setting_error(s[1]), .i_ext_defined(s[2]), .i_ext_read_only(s[3]), .i_ext_locked_in_run(s[4]),
        .i_init_memory_fault(s[5]), .i_write_storing(s[6]), .i_running(s[7]), .i_main_undervoltage(s[8]),
        .o_rsp_valid(rsp_v), .o_rsp_exception(rsp_e), .o_rsp_addr(rsp_a), .o_rsp_func(rsp_f), .o_rsp_code(rsp_c),
        .o_rsp_crc(rsp_crc), .o_write_go(wgo), .i_frame_ok(fok), .i_rd_en(rd_en), .i_rd_reg(rd_reg),
        .o_rd_valid(rd_v), .o_rd_hit(rd_h), .o_rd_data(rd_d), .i_output_short_fault(s[9]),
        .i_ground_leak_fault(s[10]), .i_input_phase_fault(s[11]), .i_output_phase_fault(s[12]),
        .i_brake_resistor_fault(s[13]), .i_brake_switch_fault(s[14]), .i_emergency_halt(s[15]),
        .i_sequence_warning(s[16]), .i_external_warning(s[17]), .i_output_blocked(s[18]),
        .i_overtorque_warning(s[19]), .i_overheat_warning(s[20]), .i_overvoltage_warning(s[21]),
        .i_cooling_fan_warning(s[22]), .i_heatsink_warning(s[23]), .i_feedback_loss(s[24]), .i_zero_speed(s[25]),
        .i_freq_agree(s[26]), .i_nonfatal_alarm(s[27]), .i_freq_detect_one(s[28]), .i_freq_detect_two(s[29]),
        .i_ready(s[30]), .i_ref_not_link(s[31]), .i_run_not_link(s[32]), .i_overtorque_detect(s[33]),
        .i_fault_retry(s[34]), .i_fault(s[35]), .i_relay_contact_out(s[36]), .i_photo_out_one(s[37]),
        .i_photo_out_two(s[38]), .i_ref_loss(s[39]), .i_err_checksum(s[40]), .i_err_length(s[41]),
        .i_err_parity(s[42]), .i_err_overrun(s[43]), .i_err_framing(s[44]), .i_input_pins(s[51:45]));
    task chk(input logic [15:0] got, want);
        check_count++;
        if (got !== want) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask : chk
    function automatic logic [15:0] crc16(input logic [23:0] m);
        logic [15:0] c = 16'hffff;
        for (int i = 0; i < 3; i++) begin
            c ^= {8'h00, m[23 - 8 * i -: 8]};
            for (int j = 0; j < 8; j++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        return c;
    endfunction : crc16
    task rd(input logic [15:0] r, want, input logic hit);
        @(posedge clk);
        rd_en <= 1'b1;
        rd_reg <= r;
        @(posedge clk);
        rd_en <= 1'b0;
        rd_reg <= ~r;
        @(negedge clk);
        chk(rd_v, 1'b1);
        chk(rd_h, hit);
        chk(rd_d, want);
    endtask : rd
    task ex(input logic [7:0] f, input logic [15:0] r, n, input logic [7:0] b, input logic [15:0] d,
            input logic [8:0] c, input logic [7:0] e);
        @(posedge clk);
        s <= {43'h0, c};
        mfl <= {f, r, n, b, d};
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(rsp_v, 1'b1);
        chk(rsp_c, e);
        chk(rsp_e, e != 8'h00);
        chk(rsp_a, sa);
        chk(rsp_f, (e != 8'h00) ? (f | 8'h80) : f);
        chk(rsp_crc, (e != 8'h00) ? crc16({sa, f | 8'h80, e}) : 16'h0000);
        chk(wgo, f == 8'h10 && e == 8'h00);
    endtask : ex
    task wr(input logic [15:0] r, input logic [8:0] c, input logic [7:0] e);
        ex(8'h10, r, 16'h1, 8'h2, 16'h0, c, e);
    endtask : wr
    task t_status;
        logic [15:0] ra [9] = '{16'h0022, 16'h0029, 16'h002a, 16'h002b, 16'h002c, 16'h002d, 16'h002e, 16'h003d, 16'h0023};
        logic [15:0] ea [9] = '{16'h0019, 16'h003f, 16'h71ff, 16'h007f, 16'h6fff, 16'h0007, 16'h0001, 16'h003b, 16'h0};
        @(posedge clk);
        s <= '1;
        fok <= 1'b1;
        repeat (4) @(posedge clk);
        for (int k = 0; k < 9; k++) rd(ra[k], ea[k], k < 8);
        @(posedge clk);
        s <= '0;
        for (int k = 0; k < 9; k++) rd(ra[k], 16'h0000, k < 8);
        $display("status done");
    endtask : t_status
    task t_timeout;
        @(posedge clk);
        fok <= 1'b0;
        repeat (30) @(posedge clk);
        rd(16'h002c, 16'h8000, 1'b1);
        rd(16'h003d, 16'h0040, 1'b1);
        @(posedge clk);
        fok <= 1'b1;
        repeat (4) @(posedge clk);
        rd(16'h002c, 16'h0000, 1'b1);
        $display("timeout done");
    endtask : t_timeout
    task t_except;
        ex(8'h04, 16'h002c, 16'h1, 8'h0, 16'h0, 9'h000, 8'h01);
        ex(8'h08, 16'h0000, 16'h1, 8'h0, 16'h0, 9'h000, 8'h00);
        ex(8'h03, 16'h0500, 16'h1, 8'h0, 16'h0, 9'h000, 8'h02);
        ex(8'h03, 16'h0900, 16'h1, 8'h0, 16'h0, 9'h000, 8'h02);
        ex(8'h03, 16'h002c, 16'h0, 8'h0, 16'h0, 9'h000, 8'h03);
        ex(8'h03, 16'h002c, 16'h11, 8'h0, 16'h0, 9'h000, 8'h03);
        ex(8'h03, 16'h002c, 16'h10, 8'h0, 16'h0, 9'h000, 8'h00);
        ex(8'h10, 16'h0500, 16'h2, 8'h3, 16'h0, 9'h004, 8'h03);
        wr(16'h0500, 9'h005, 8'h21);
        wr(16'h0500, 9'h006, 8'h21);
        wr(16'h0500, 9'h094, 8'h22);
        wr(16'h0900, 9'h080, 8'h22);
        wr(16'h0500, 9'h104, 8'h22);
        wr(16'h0900, 9'h100, 8'h22);
        wr(16'h0500, 9'h024, 8'h22);
        ex(8'h10, 16'h0101, 16'h1, 8'h2, 16'h8, 9'h024, 8'h00);
        ex(8'h10, 16'h0101, 16'h1, 8'h2, 16'h9, 9'h024, 8'h00);
        wr(16'h0500, 9'h044, 8'h22);
        wr(16'h002c, 9'h000, 8'h22);
        wr(16'h0500, 9'h00c, 8'h22);
        wr(16'h0500, 9'h004, 8'h00);
        rd(16'h002c, 16'h0000, 1'b1);
        $display("exceptions done");
    endtask : t_except
    task summarize;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_status();
        t_timeout();
        t_except();
        summarize();
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule : tb
